// >>> hw/bbc_pkg.sv
// package of constants and types for the backlight and bias control register bank
// Operation
// [R1] burst write stores each data byte at the next higher register address
// [R2] writing one to bit 7 of register 0x08 starts a software reset
// [R3] software reset returns every register to its default value
// [R4] after restoring, the device clears the reset bit itself
// [R5] read-only identification register at 0x01 holds vendor and revision fields
// [R6] string lights only when its enable and master enable are both set
// [R7] over-voltage threshold field at 0x02, default meaning 21 V
// [R8] register 0x11 holds minimum inductor and current limit fields
// [R9] burst read returns consecutive registers from a start address
// [R10] reset bit reads one while a software reset is in progress
package bbc_pkg;
    localparam logic [7:0] ADDR_IDENT = 8'h01;
    localparam logic [7:0] ADDR_OVP = 8'h02;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_INDUCTOR = 8'h11;
    // enable register fields
    localparam int SWR_BIT = 7;
    localparam int MASTER_BIT = 4;
    localparam int STRING_LSB = 0;
    localparam int NUM_STRINGS = 4;
    // inductor register fields
    localparam int LMIN_LSB = 0;
    localparam int OCP_LSB = 4;
    // reset values; ovp default code stands for the 21 V threshold
    localparam logic [7:0] OVP_RESET = 8'h01;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] INDUCTOR_RESET = 8'h00;
    // identity values are arbitrary
    localparam logic [3:0] VENDOR_CODE = 4'h5;
    localparam logic [3:0] REVISION_CODE = 4'h3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // cycles the software reset stays visible
    localparam int SWR_CYCLES = 2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bbc_req_t;

    typedef struct packed {
        logic [NUM_STRINGS-1:0] string_on;
        logic [7:0] ovp_level;
        logic [3:0] lmin_sel;
        logic [3:0] ocp_sel;
    } bbc_ctrl_t;
endpackage : bbc_pkg

// >>> hw/bbc_addr_ptr.sv
// auto-advancing register address pointer used for burst access
`timescale 1ns/100ps
module bbc_addr_ptr #(
    parameter int AW = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [AW-1:0] load_addr,
    input wire logic step,
    output logic [AW-1:0] addr
);
    // elaboration check: the pointer must reach every register of the map
    if (AW < 5) begin : g_bad_aw
        $error("address width too small for the map");
    end

    // load wins over step so a fresh start address is never skipped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr <= '0;
        end else if (load) begin
            addr <= load_addr;
        end else if (step) begin
            addr <= addr + AW'(1);
        end
    end
endmodule : bbc_addr_ptr

// >>> hw/bbc_regs.sv
// register bank of the backlight driver, reached by byte requests from the serial slave
`timescale 1ns/100ps
module bbc_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] start_addr,
    input wire bbc_pkg::bbc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [7:0] cur_addr,
    output logic swr_busy,
    output bbc_pkg::bbc_ctrl_t ctrl
);
    typedef enum logic [1:0] {
        BBC_IDLE = 2'b01,
        BBC_SWR = 2'b10
    } bbc_state_t;

    bbc_state_t state;
    logic [7:0] ovp;
    logic [7:0] enable;
    logic [7:0] inductor;
    logic [1:0] swr_cnt;
    logic swr_hit;
    logic [7:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks: the reset length must fit the two bit counter and the field layout must fit one byte
    if (bbc_pkg::SWR_CYCLES < 1 || bbc_pkg::SWR_CYCLES > 4) begin : g_bad_swr_len
        $error("software reset length does not fit the two bit counter");
    end
    if (bbc_pkg::STRING_LSB + bbc_pkg::NUM_STRINGS > bbc_pkg::MASTER_BIT) begin : g_bad_strings
        $error("string enables overlap the master enable");
    end
    if (bbc_pkg::MASTER_BIT >= bbc_pkg::SWR_BIT) begin : g_bad_master
        $error("master enable overlaps the reset bit");
    end
    if (bbc_pkg::LMIN_LSB + 4 > bbc_pkg::OCP_LSB || bbc_pkg::OCP_LSB + 4 > 8) begin : g_bad_ind
        $error("inductor and current limit fields overlap or overflow");
    end

    ////////////////////////////////////////////////////////////////////////////
    // [R1] burst address advance, each byte moves to the next register
    bbc_addr_ptr #(.AW(8)) u_ptr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(start),
        .load_addr(start_addr),
        .step(req.wr | req.rd),
        .addr(cur_addr)
    );

    // [R2] reset command detect
    assign swr_hit = req.wr && !start && cur_addr == bbc_pkg::ADDR_ENABLE
        && req.wdata[bbc_pkg::SWR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // [R4] self-clearing reset sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= BBC_IDLE;
            swr_cnt <= '0;
        end else begin
            unique case (state)
                BBC_IDLE: begin
                    if (swr_hit) begin
                        state <= BBC_SWR;
                        swr_cnt <= 2'(bbc_pkg::SWR_CYCLES - 1);
                    end
                end
                BBC_SWR: begin
                    if (swr_cnt == '0) state <= BBC_IDLE;
                    else swr_cnt <= swr_cnt - 2'(1);
                end
                default: state <= BBC_IDLE;
            endcase
        end
    end

    // busy is a plain decode of the one-hot state, so it needs no extra flop
    assign swr_busy = (state == BBC_SWR);

    // [R4] helper count of busy cycles, lets the length be checked for any setting
    logic [2:0] busy_run;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !swr_busy) begin
            busy_run <= '0;
        end else begin
            busy_run <= busy_run + 3'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [R3] defaults restored while reset runs; writes then are ignored
    always_ff @(posedge sys_clk) begin
        if (!rst_n || swr_hit || swr_busy) begin
            ovp <= bbc_pkg::OVP_RESET;
            enable <= bbc_pkg::ENABLE_RESET;
            inductor <= bbc_pkg::INDUCTOR_RESET;
        end else if (req.wr && !start) begin
            // [R7] [R8] writable fields
            unique case (cur_addr)
                bbc_pkg::ADDR_OVP: ovp <= req.wdata;
                bbc_pkg::ADDR_ENABLE: enable <= {1'b0, req.wdata[6:0]};
                bbc_pkg::ADDR_INDUCTOR: inductor <= req.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [R9] read mux over consecutive addresses
    always_comb begin
        next_rdata = bbc_pkg::READ_UNMAPPED;
        unique case (cur_addr)
            // [R5] fixed identity, writes have no effect
            bbc_pkg::ADDR_IDENT: next_rdata = {bbc_pkg::VENDOR_CODE, bbc_pkg::REVISION_CODE};
            bbc_pkg::ADDR_OVP: next_rdata = ovp;
            // [R10] reset bit reads one while busy
            bbc_pkg::ADDR_ENABLE: next_rdata = {swr_busy, enable[6:0]};
            bbc_pkg::ADDR_INDUCTOR: next_rdata = inductor;
            default: next_rdata = bbc_pkg::READ_UNMAPPED;
        endcase
    end

    // registered read data, held until the next read so a slow host can take it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata <= '0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd && !start;
            if (req.rd && !start) rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [R6] string outputs gated by master enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl.string_on <= enable[bbc_pkg::STRING_LSB +: bbc_pkg::NUM_STRINGS]
                & {bbc_pkg::NUM_STRINGS{enable[bbc_pkg::MASTER_BIT]}};
            ctrl.ovp_level <= ovp;
            ctrl.lmin_sel <= inductor[bbc_pkg::LMIN_LSB +: 4];
            ctrl.ocp_sel <= inductor[bbc_pkg::OCP_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_swr_sets_busy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
        swr_hit |=> swr_busy) else $error("reset command did not start reset");
    chk_swr_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
        swr_hit |=> swr_busy ##1 swr_busy ##1 !swr_busy) else $error("reset bit stuck");
    chk_swr_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
        swr_hit |=> ovp == bbc_pkg::OVP_RESET && enable == bbc_pkg::ENABLE_RESET
        && inductor == bbc_pkg::INDUCTOR_RESET) else $error("defaults not restored");
    chk_ident_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
        req.rd && !start && cur_addr == bbc_pkg::ADDR_IDENT |=>
        rvalid && rdata == {bbc_pkg::VENDOR_CODE, bbc_pkg::REVISION_CODE})
        else $error("identity read wrong");
    chk_string_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
        !enable[bbc_pkg::MASTER_BIT] |=> ctrl.string_on == '0)
        else $error("string on without master enable");
    chk_burst_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
        req.wr && !start |=> cur_addr == $past(cur_addr) + 8'h01)
        else $error("burst address did not advance");
    chk_ovp_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
        req.wr && !start && !swr_busy && cur_addr == bbc_pkg::ADDR_OVP |=> ##1
        ctrl.ovp_level == $past(req.wdata, 2)) else $error("ovp write lost");
    chk_busy_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
        req.rd && !start && swr_busy && cur_addr == bbc_pkg::ADDR_ENABLE |=>
        rdata[bbc_pkg::SWR_BIT]) else $error("reset bit not visible");

    ////////////////////////////////////////////////////////////////////////////
    // pointer and read path checks
    // [R1] a start strobe loads the pointer whatever else is requested
    chk_start_load: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
        start |=> cur_addr == $past(start_addr)) else $error("start address not loaded");
    // [R9] a read steps the pointer like a write does
    chk_read_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        req.rd && !start |=> cur_addr == $past(cur_addr) + 8'h01)
        else $error("burst read address did not advance");
    // [R9] the read strobe comes exactly one cycle after each read request
    chk_read_valid: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        req.rd && !start |=> rvalid) else $error("read strobe missing");
    chk_no_stray_valid: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        !(req.rd && !start) |=> !rvalid) else $error("read strobe without request");
    // [R9] read data stands until the next read
    chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        !(req.rd && !start) |=> $stable(rdata)) else $error("read data changed without read");
    // [R9] places without a register read as the unmapped value
    chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        req.rd && !start && cur_addr != bbc_pkg::ADDR_IDENT && cur_addr != bbc_pkg::ADDR_OVP
        && cur_addr != bbc_pkg::ADDR_ENABLE && cur_addr != bbc_pkg::ADDR_INDUCTOR
        |=> rdata == bbc_pkg::READ_UNMAPPED) else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////////////////
    // reset and output stage checks
    // [R3] writes that land while the reset runs are dropped
    chk_swr_blocks_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
        swr_busy |=> ovp == bbc_pkg::OVP_RESET && enable == bbc_pkg::ENABLE_RESET
        && inductor == bbc_pkg::INDUCTOR_RESET) else $error("write landed during reset");
    // [R4] busy lasts exactly the programmed number of cycles
    chk_busy_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
        swr_busy |-> busy_run < 3'(bbc_pkg::SWR_CYCLES)) else $error("reset runs too long");
    chk_busy_full: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
        $fell(swr_busy) |-> busy_run == 3'(bbc_pkg::SWR_CYCLES)) else $error("reset ended early");
    // [R6] with the master enable set each string follows its own bit
    chk_string_follow: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
        enable[bbc_pkg::MASTER_BIT] |=>
        ctrl.string_on == $past(enable[bbc_pkg::STRING_LSB +: bbc_pkg::NUM_STRINGS]))
        else $error("string output does not follow its enable");
    // [R8] both inductor fields reach the outputs two cycles after the write
    chk_inductor_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
        req.wr && !start && !swr_busy && cur_addr == bbc_pkg::ADDR_INDUCTOR |=> ##1
        {ctrl.ocp_sel, ctrl.lmin_sel} == $past(req.wdata, 2))
        else $error("inductor write lost");
    // [R6] an enable write keeps the low seven bits and never stores the reset bit
    chk_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
        req.wr && !start && !swr_busy && !swr_hit && cur_addr == bbc_pkg::ADDR_ENABLE |=>
        enable == {1'b0, $past(req.wdata[6:0])}) else $error("enable write lost");
endmodule : bbc_regs

// >>> sim/bbc_host.sv
// host model that drives byte requests into the register bank
`timescale 1ns/100ps
module bbc_host (
    input wire logic sys_clk,
    output logic start,
    output logic [7:0] start_addr,
    output bbc_pkg::bbc_req_t req
);
    // address the host believes the pointer holds, shown on the spare address field
    logic [7:0] addr_track;
    // idle from time zero; after each pulse the stale start address and write data are inverted so they never look valid
    initial begin
        start = 1'b0;
        start_addr = 8'h00;
        req = '0;
        addr_track = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one start address before the data bytes
    task automatic open(input logic [7:0] a);
        @(posedge sys_clk) start <= 1'b1;
        start_addr <= a;
        addr_track = a;
        @(posedge sys_clk) start <= 1'b0;
        start_addr <= ~a;
    endtask : open
    // one byte, the device steps the address
    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk) req.wr <= 1'b1;
        req.wdata <= d;
        req.addr <= addr_track;
        addr_track = addr_track + 8'h01;
        @(posedge sys_clk) req.wr <= 1'b0;
        req.wdata <= ~d;
    endtask : wr
    // one read pulse, the device steps the address
    task automatic rd();
        @(posedge sys_clk) req.rd <= 1'b1;
        req.addr <= addr_track;
        addr_track = addr_track + 8'h01;
        @(posedge sys_clk) req.rd <= 1'b0;
    endtask : rd
    // reset command, reload of the same address, then a read while it runs
    task automatic swr_poll(input logic [7:0] a);
        @(posedge sys_clk) req.wr <= 1'b1;
        req.wdata <= 8'h80;
        req.addr <= a;
        @(posedge sys_clk) req.wr <= 1'b0;
        req.wdata <= 8'h7F;
        start <= 1'b1;
        start_addr <= a;
        @(posedge sys_clk) start <= 1'b0;
        start_addr <= ~a;
        req.rd <= 1'b1;
        req.addr <= a;
        addr_track = a + 8'h01;
        @(posedge sys_clk) req.rd <= 1'b0;
    endtask : swr_poll
endmodule : bbc_host

// >>> sim/tb_top.sv
// self-checking bench for the backlight control register bank
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start;
    logic [7:0] start_addr;
    bbc_pkg::bbc_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] cur_addr;
    logic swr_busy;
    bbc_pkg::bbc_ctrl_t ctrl;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    // free running clock, 10 ns period
    always #5 sys_clk = ~sys_clk;
    bbc_host host (.sys_clk(sys_clk), .start(start), .start_addr(start_addr), .req(req));
    bbc_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .start_addr(start_addr),
        .req(req), .rdata(rdata), .rvalid(rvalid), .cur_addr(cur_addr),
        .swr_busy(swr_busy), .ctrl(ctrl));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    // rvalid stands one cycle, so it is looked at just after its edge
    task automatic read_exp(input logic [7:0] exp);
        host.rd();
        #1;
        cmp8({7'h00, rvalid}, 8'h01);
        cmp8(rdata, exp);
    endtask : read_exp
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        host.open(bbc_pkg::ADDR_IDENT);
        read_exp({bbc_pkg::VENDOR_CODE, bbc_pkg::REVISION_CODE});
        read_exp(bbc_pkg::OVP_RESET);
        host.open(bbc_pkg::ADDR_INDUCTOR);
        read_exp(bbc_pkg::INDUCTOR_RESET);
    endtask : t_defaults
    // the write to the read-only place must not land, yet the next byte must
    task automatic t_burst();
        host.open(bbc_pkg::ADDR_IDENT);
        host.wr(8'hAA);
        host.wr(8'h05);
        #1;
        cmp8(cur_addr, 8'h03);
        host.open(bbc_pkg::ADDR_IDENT);
        read_exp({bbc_pkg::VENDOR_CODE, bbc_pkg::REVISION_CODE});
        read_exp(8'h05);
        read_exp(bbc_pkg::READ_UNMAPPED);
    endtask : t_burst
    task automatic t_enable();
        host.open(bbc_pkg::ADDR_ENABLE);
        host.wr(8'h0F);
        settle();
        cmp8({4'h0, ctrl.string_on}, 8'h00);
        host.open(bbc_pkg::ADDR_ENABLE);
        host.wr(8'h1A);
        settle();
        cmp8({4'h0, ctrl.string_on}, 8'h0A);
        host.open(bbc_pkg::ADDR_INDUCTOR);
        host.wr(8'h3C);
        settle();
        cmp8({ctrl.ocp_sel, ctrl.lmin_sel}, 8'h3C);
    endtask : t_enable
    task automatic t_swr();
        host.open(bbc_pkg::ADDR_ENABLE);
        host.wr(8'h80);
        #1;
        cmp8({7'h00, swr_busy}, 8'h01);
        settle();
        cmp8({7'h00, swr_busy}, 8'h00);
        cmp8(ctrl.ovp_level, bbc_pkg::OVP_RESET);
        host.open(bbc_pkg::ADDR_ENABLE);
        read_exp(bbc_pkg::ENABLE_RESET);
        host.open(bbc_pkg::ADDR_INDUCTOR);
        read_exp(bbc_pkg::INDUCTOR_RESET);
    endtask : t_swr
    // the reset bit is polled while the reset still runs, then the strings must be off
    task automatic t_swr_poll();
        host.open(bbc_pkg::ADDR_ENABLE);
        host.wr(8'h1F);
        settle();
        cmp8({4'h0, ctrl.string_on}, 8'h0F);
        host.open(bbc_pkg::ADDR_ENABLE);
        host.swr_poll(bbc_pkg::ADDR_ENABLE);
        #1;
        cmp8({7'h00, rvalid}, 8'h01);
        cmp8(rdata, bbc_pkg::ENABLE_RESET | 8'h80);
        settle();
        cmp8({4'h0, ctrl.string_on}, 8'h00);
    endtask : t_swr_poll
    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far above the fewer than a hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            summarize();
        end
    end
    // reset for 8 cycles, then the scenarios in order
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_defaults();
        t_burst();
        t_enable();
        t_swr();
        t_swr_poll();
        summarize();
    end
endmodule : tb_top
